// *** hw/dscc_config.sv ***
// Serial and fieldbus communication settings of the drive, with delayed command replies
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Word bits 0-3: std language, address, ack, checksum
// - Word bit 4 adaptor, bit 5 3-digit addressing
// - Word bits 6-8: checksum type, endian, wires
// - Word written and read back as value
// - Reply waits programmable delay 0-100, default 2
// - Bit-rate codes 1-5 decode 9600 to 115200
// - After one second, stored rate taken if mode
// - Bit-rate command accepted when no write is pending and no reply is in progress
// - Address 1-32, default 32, mapped to character
// - Node identifier 1-127, default 1
// - Same index selects network address or DHCP
// - Fieldbus rate codes 0-7, 1M down to 12.5K
module dscc_config #(
    parameter int TD_UNIT_CYCLES = dscc_pkg::TD_UNIT_CYCLES,
    parameter int POWERUP_CYCLES = dscc_pkg::POWERUP_CYCLES
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_write_in,
    input  wire logic [2:0]  cmd_sel_in,
    input  wire logic [15:0] cmd_data_in,
    input  wire logic        msg_busy_in,
    input  wire logic [3:0]  power_up_operating_mode_in,
    input  wire logic [2:0]  nv_bit_rate_code_in,
    output logic             cmd_ready_out,
    output logic             reply_valid_out,
    output logic [15:0]      reply_data_out,
    output logic             reply_nak_out,
    output logic [8:0]       protocol_settings_out,
    output logic [6:0]       reply_transmit_delay_out,
    output logic [2:0]       serial_bit_rate_code_out,
    output logic [16:0]      serial_bit_rate_bps_out,
    output logic [5:0]       multidrop_drive_address_out,
    output logic [7:0]       drive_address_char_out,
    output logic [6:0]       node_id_or_net_index_out,
    output logic [31:0]      net_address_out,
    output logic             net_dhcp_out,
    output logic [2:0]       fieldbus_bit_rate_code_out,
    output logic [19:0]      fieldbus_bit_rate_bps_out,
    output logic             powerup_done_out
);
    localparam int PU_W = $clog2(POWERUP_CYCLES + 1);
    localparam int DW   = dscc_pkg::DLY_W;

    // Stored settings
    logic [8:0]  proto_q, proto_d;
    logic [6:0]  td_q, td_d;
    logic [2:0]  br_q, br_d;
    logic [5:0]  da_q, da_d;
    logic [6:0]  co_q, co_d;
    logic [2:0]  cb_q, cb_d;

    // Pending write, held while a message is in flight
    logic        pend_q;
    logic [2:0]  pend_sel_q;
    logic [15:0] pend_data_q;

    // Power-up rate switch
    logic [PU_W-1:0] pu_cnt_q;
    logic            pu_done_q;

    // Reply timer
    logic          tmr_busy;
    logic          tmr_done;
    logic [DW-1:0] td_cycles;

    // Command decode
    wire accept    = cmd_valid_in && cmd_ready_out;
    wire ok_proto  = cmd_data_in <= dscc_pkg::PROTO_MAX;
    wire ok_td     = cmd_data_in <= dscc_pkg::TD_MAX;
    wire ok_br     = cmd_data_in >= dscc_pkg::BR_MIN && cmd_data_in <= dscc_pkg::BR_MAX;
    wire ok_da     = cmd_data_in >= dscc_pkg::DA_MIN && cmd_data_in <= dscc_pkg::DA_MAX;
    wire ok_co     = cmd_data_in >= dscc_pkg::CO_MIN && cmd_data_in <= dscc_pkg::CO_MAX;
    wire ok_cb     = cmd_data_in <= dscc_pkg::CB_MAX;
    wire sel_known = cmd_sel_in <= dscc_pkg::SEL_CB;
    wire wr_ok     = (cmd_sel_in == dscc_pkg::SEL_PROTO) ? ok_proto :
                     (cmd_sel_in == dscc_pkg::SEL_TD)    ? ok_td    :
                     (cmd_sel_in == dscc_pkg::SEL_BR)    ? ok_br    :
                     (cmd_sel_in == dscc_pkg::SEL_DA)    ? ok_da    :
                     (cmd_sel_in == dscc_pkg::SEL_CO)    ? ok_co    :
                     (cmd_sel_in == dscc_pkg::SEL_CB)    ? ok_cb    : 1'b0;
    wire wr_take   = accept && cmd_write_in && wr_ok;
    wire ack_en    = proto_q[dscc_pkg::PR_ACK_NAK];
    wire rep_start = accept && (!cmd_write_in || ack_en);
    wire [15:0] rd_val =
        (cmd_sel_in == dscc_pkg::SEL_PROTO) ? {7'h00, proto_q} :
        (cmd_sel_in == dscc_pkg::SEL_TD)    ? {9'h000, td_q}   :
        (cmd_sel_in == dscc_pkg::SEL_BR)    ? {13'h0000, br_q} :
        (cmd_sel_in == dscc_pkg::SEL_DA)    ? {10'h000, da_q}  :
        (cmd_sel_in == dscc_pkg::SEL_CO)    ? {9'h000, co_q}   :
        (cmd_sel_in == dscc_pkg::SEL_CB)    ? {13'h0000, cb_q} : 16'h0000;
    wire rep_nak   = cmd_write_in ? !wr_ok : !sel_known;

    // Pending write lands once the current message is over
    wire apply     = pend_q && !msg_busy_in;
    wire ap_proto  = apply && pend_sel_q == dscc_pkg::SEL_PROTO;
    wire ap_td     = apply && pend_sel_q == dscc_pkg::SEL_TD;
    wire ap_br     = apply && pend_sel_q == dscc_pkg::SEL_BR;
    wire ap_da     = apply && pend_sel_q == dscc_pkg::SEL_DA;
    wire ap_co     = apply && pend_sel_q == dscc_pkg::SEL_CO;
    wire ap_cb     = apply && pend_sel_q == dscc_pkg::SEL_CB;

    // Power-up: stored bit rate taken only in command-language or queued mode
    wire pu_fire   = !pu_done_q && (pu_cnt_q == PU_W'(POWERUP_CYCLES - 1));
    wire pm_ok     = power_up_operating_mode_in == dscc_pkg::PM_CMD_LANG ||
                     power_up_operating_mode_in == dscc_pkg::PM_QUEUED;
    wire nv_ok     = nv_bit_rate_code_in >= dscc_pkg::BR_MIN[2:0] &&
                     nv_bit_rate_code_in <= dscc_pkg::BR_MAX[2:0];
    wire pu_take   = pu_fire && pm_ok && nv_ok;

    assign proto_d = ap_proto ? pend_data_q[8:0] : proto_q;
    assign td_d    = ap_td    ? pend_data_q[6:0] : td_q;
    assign br_d    = ap_br    ? pend_data_q[2:0] :
                     pu_take  ? nv_bit_rate_code_in : br_q;
    assign da_d    = ap_da    ? pend_data_q[5:0] : da_q;
    assign co_d    = ap_co    ? pend_data_q[6:0] : co_q;
    assign cb_d    = ap_cb    ? pend_data_q[2:0] : cb_q;

    // A new command waits for the pending write and any reply in progress
    assign cmd_ready_out   = !pend_q && !tmr_busy;
    assign reply_valid_out = tmr_done;
    assign td_cycles       = DW'(td_q) * DW'(TD_UNIT_CYCLES);

    dscc_reply_timer #(
        .CNT_W (DW)
    ) u_reply_timer (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .start_in   (rep_start),
        .load_in    (td_cycles),
        .busy_out   (tmr_busy),
        .done_out   (tmr_done)
    );

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            proto_q <= dscc_pkg::PROTO_RST;
            td_q    <= dscc_pkg::TD_RST;
            br_q    <= dscc_pkg::BR_RST;
            da_q    <= dscc_pkg::DA_RST;
            co_q    <= dscc_pkg::CO_RST;
            cb_q    <= dscc_pkg::CB_RST;
        end else begin
            proto_q <= proto_d;
            td_q    <= td_d;
            br_q    <= br_d;
            da_q    <= da_d;
            co_q    <= co_d;
            cb_q    <= cb_d;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q      <= 1'b0;
            pend_sel_q  <= 3'h0;
            pend_data_q <= 16'h0000;
        end else if (wr_take) begin
            pend_q      <= 1'b1;
            pend_sel_q  <= cmd_sel_in;
            pend_data_q <= cmd_data_in;
        end else if (apply) begin
            pend_q      <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reply_data_out <= 16'h0000;
            reply_nak_out  <= 1'b0;
        end else if (rep_start) begin
            reply_data_out <= cmd_write_in ? 16'h0000 : rd_val;
            reply_nak_out  <= rep_nak;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pu_cnt_q  <= '0;
            pu_done_q <= 1'b0;
        end else if (pu_fire) begin
            pu_done_q <= 1'b1;
        end else if (!pu_done_q) begin
            pu_cnt_q  <= pu_cnt_q + PU_W'(1);
        end
    end

    // Registered views of the settings
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            protocol_settings_out       <= dscc_pkg::PROTO_RST;
            reply_transmit_delay_out    <= dscc_pkg::TD_RST;
            serial_bit_rate_code_out    <= dscc_pkg::BR_RST;
            serial_bit_rate_bps_out     <= dscc_pkg::serial_bps(dscc_pkg::BR_RST);
            multidrop_drive_address_out <= dscc_pkg::DA_RST;
            drive_address_char_out      <= dscc_pkg::addr_char(dscc_pkg::DA_RST);
            node_id_or_net_index_out    <= dscc_pkg::CO_RST;
            net_address_out             <= dscc_pkg::net_ip(dscc_pkg::CO_RST[3:0]);
            net_dhcp_out                <= 1'b0;
            fieldbus_bit_rate_code_out  <= dscc_pkg::CB_RST;
            fieldbus_bit_rate_bps_out   <= dscc_pkg::fieldbus_bps(dscc_pkg::CB_RST);
            powerup_done_out            <= 1'b0;
        end else begin
            protocol_settings_out       <= proto_q;
            reply_transmit_delay_out    <= td_q;
            serial_bit_rate_code_out    <= br_q;
            serial_bit_rate_bps_out     <= dscc_pkg::serial_bps(br_q);
            multidrop_drive_address_out <= da_q;
            drive_address_char_out      <= dscc_pkg::addr_char(da_q);
            node_id_or_net_index_out    <= co_q;
            net_address_out             <= dscc_pkg::net_ip(co_q[3:0]);
            net_dhcp_out                <= co_q[3:0] == dscc_pkg::NET_DHCP_IDX;
            fieldbus_bit_rate_code_out  <= cb_q;
            fieldbus_bit_rate_bps_out   <= dscc_pkg::fieldbus_bps(cb_q);
            powerup_done_out            <= pu_done_q;
        end
    end

    // Assertion helpers: cycles spent waiting and the wait that was loaded
    logic [DW-1:0] wait_cnt_q;
    logic [DW-1:0] wait_exp_q;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_cnt_q <= '0;
            wait_exp_q <= '0;
        end else if (rep_start) begin
            wait_cnt_q <= '0;
            wait_exp_q <= td_cycles;
        end else if (tmr_busy && !tmr_done) begin
            wait_cnt_q <= wait_cnt_q + DW'(1);
        end
    end

    property p_reply_delay;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        reply_valid_out |-> (wait_cnt_q == wait_exp_q);
    endproperty
    a_reply_delay: assert property (p_reply_delay) else $error("Reply left before delay");

    property p_td_range;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ##1 (16'(td_q) <= dscc_pkg::TD_MAX);
    endproperty
    a_td_range: assert property (p_td_range) else $error("Delay setting out of range");

    property p_proto_write;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ap_proto |=> {7'h00, proto_q} == $past(pend_data_q) ##1
                     protocol_settings_out == $past(proto_q);
    endproperty
    a_proto_write: assert property (p_proto_write) else $error("Protocol word not stored");

    property p_read_back;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (accept && !cmd_write_in && cmd_sel_in == dscc_pkg::SEL_PROTO)
            |=> reply_data_out == {7'h00, $past(proto_q)} && !reply_nak_out;
    endproperty
    a_read_back: assert property (p_read_back) else $error("Protocol read wrong value");

    property p_reject;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (accept && cmd_write_in && !wr_ok) |=> !pend_q ##0 $stable(proto_q) ##0
                                               $stable(da_q) ##0 $stable(co_q);
    endproperty
    a_reject: assert property (p_reject) else $error("Bad write was stored");

    property p_hold_busy;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (pend_q && msg_busy_in) |=> $stable(proto_q) && $stable(td_q) &&
                                    $stable(da_q) && $stable(cb_q) && pend_q;
    endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("Setting changed mid message");

    property p_rate_write;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ap_br |=> {13'h0000, br_q} == $past(pend_data_q) ##1
                  serial_bit_rate_bps_out == dscc_pkg::serial_bps($past(br_q));
    endproperty
    a_rate_write: assert property (p_rate_write) else $error("Bit rate not applied");

    property p_powerup;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (pu_take && !ap_br) |=> br_q == $past(nv_bit_rate_code_in) && pu_done_q;
    endproperty
    a_powerup: assert property (p_powerup) else $error("Power-up rate not taken");

    property p_addr_char;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (da_q == dscc_pkg::DA_LAST) |=> drive_address_char_out == dscc_pkg::CHAR_DIGIT;
    endproperty
    a_addr_char: assert property (p_addr_char) else $error("Address 32 char wrong");

    property p_node_range;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ##1 co_q != 7'h00;
    endproperty
    a_node_range: assert property (p_node_range) else $error("Node id zero");

    property p_fb_slowest;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (cb_q == 3'h7) |=> fieldbus_bit_rate_bps_out == 20'h030D4;
    endproperty
    a_fb_slowest: assert property (p_fb_slowest) else $error("Fieldbus rate decode wrong");

    c_reply_wait: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
                                  rep_start ##[2:300] reply_valid_out);
    c_rejected:   cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
                                  accept && cmd_write_in && !wr_ok);
    c_held:       cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
                                  pend_q && msg_busy_in ##1 apply);
    c_powerup:    cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) pu_take);
endmodule // dscc_config
`default_nettype wire

// *** hw/dscc_pkg.sv ***
// Package: constants, encodings and decode tables for the serial comm configuration block
package dscc_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS    = 8;
    localparam int TD_UNIT_NS       = 1000000;
    localparam int TD_UNIT_CYCLES   = TD_UNIT_NS / CLK_PERIOD_NS;
    localparam int POWERUP_DELAY_MS = 1000;
    localparam int POWERUP_CYCLES   = POWERUP_DELAY_MS * 1000000 / CLK_PERIOD_NS;

    // Widths
    localparam int DATA_W  = 16;
    localparam int PROTO_W = 9;
    localparam int DLY_W   = 24;

    // Setting selects on the command port
    localparam logic [2:0] SEL_PROTO = 3'h0;
    localparam logic [2:0] SEL_TD    = 3'h1;
    localparam logic [2:0] SEL_BR    = 3'h2;
    localparam logic [2:0] SEL_DA    = 3'h3;
    localparam logic [2:0] SEL_CO    = 3'h4;
    localparam logic [2:0] SEL_CB    = 3'h5;

    // Protocol settings word bit positions
    localparam int PR_STD_LANG    = 0;
    localparam int PR_ADDR_ALWAYS = 1;
    localparam int PR_ACK_NAK     = 2;
    localparam int PR_CSUM_RSVD   = 3;
    localparam int PR_RS485_ADAPT = 4;
    localparam int PR_REG_3DIGIT  = 5;
    localparam int PR_CSUM_TYPE   = 6;
    localparam int PR_ENDIAN      = 7;
    localparam int PR_FOUR_WIRE   = 8;

    // Reset values and ranges
    localparam logic [8:0]  PROTO_RST = 9'h00F;
    localparam logic [15:0] PROTO_MAX = 16'h01FF;
    localparam logic [6:0]  TD_RST    = 7'h02;
    localparam logic [15:0] TD_MAX    = 16'h0064;
    localparam logic [2:0]  BR_RST    = 3'h1;
    localparam logic [15:0] BR_MIN    = 16'h0001;
    localparam logic [15:0] BR_MAX    = 16'h0005;
    localparam logic [5:0]  DA_RST    = 6'h20;
    localparam logic [15:0] DA_MIN    = 16'h0001;
    localparam logic [15:0] DA_MAX    = 16'h0020;
    localparam logic [6:0]  CO_RST    = 7'h01;
    localparam logic [15:0] CO_MIN    = 16'h0001;
    localparam logic [15:0] CO_MAX    = 16'h007F;
    localparam logic [2:0]  CB_RST    = 3'h0;
    localparam logic [15:0] CB_MAX    = 16'h0007;

    // Power-up operating modes that take the stored bit rate
    localparam logic [3:0] PM_CMD_LANG = 4'h1;
    localparam logic [3:0] PM_QUEUED   = 4'h2;

    // Address character split points
    localparam logic [5:0] DA_DIGIT_TOP = 6'h10;
    localparam logic [5:0] DA_LAST      = 6'h20;
    localparam logic [7:0] CHAR_DIGIT   = 8'h30;
    localparam logic [7:0] CHAR_PUNCT   = 8'h10;

    // Network index
    localparam logic [3:0]  NET_DHCP_IDX = 4'hF;
    localparam logic [31:0] NET_IP_ZERO  = 32'h0A0A0A0A;
    localparam logic [23:0] NET_PFX_ONE  = 24'hC0A801;
    localparam logic [23:0] NET_PFX_ZERO = 24'hC0A800;
    localparam logic [3:0]  NET_ONE_TOP  = 4'h3;

    function automatic logic [16:0] serial_bps(input logic [2:0] code);
        case (code)
            3'h1:    serial_bps = 17'h02580;
            3'h2:    serial_bps = 17'h04B00;
            3'h3:    serial_bps = 17'h09600;
            3'h4:    serial_bps = 17'h0E100;
            3'h5:    serial_bps = 17'h1C200;
            default: serial_bps = 17'h00000;
        endcase
    endfunction

    function automatic logic [19:0] fieldbus_bps(input logic [2:0] code);
        case (code)
            3'h0:    fieldbus_bps = 20'hF4240;
            3'h1:    fieldbus_bps = 20'hC3500;
            3'h2:    fieldbus_bps = 20'h7A120;
            3'h3:    fieldbus_bps = 20'h3D090;
            3'h4:    fieldbus_bps = 20'h1E848;
            3'h5:    fieldbus_bps = 20'h0C350;
            3'h6:    fieldbus_bps = 20'h061A8;
            default: fieldbus_bps = 20'h030D4;
        endcase
    endfunction

    function automatic logic [7:0] addr_char(input logic [5:0] addr);
        if (addr == DA_LAST)
            addr_char = CHAR_DIGIT;
        else if (addr <= DA_DIGIT_TOP)
            addr_char = CHAR_DIGIT + {2'h0, addr};
        else
            addr_char = CHAR_PUNCT + {2'h0, addr};
    endfunction

    function automatic logic [31:0] net_ip(input logic [3:0] idx);
        logic [7:0] host;
        host = 8'({4'h0, idx} * 8'h0A);
        if (idx == 4'h0)
            net_ip = NET_IP_ZERO;
        else if (idx <= NET_ONE_TOP)
            net_ip = {NET_PFX_ONE, host};
        else if (idx == NET_DHCP_IDX)
            net_ip = 32'h00000000;
        else
            net_ip = {NET_PFX_ZERO, host};
    endfunction

endpackage

// *** hw/dscc_reply_timer.sv ***
// Down-counter that holds a reply back for a programmed number of cycles
`timescale 1ns/1ns
`default_nettype none
module dscc_reply_timer #(
    parameter int CNT_W = dscc_pkg::DLY_W
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             start_in,
    input  wire logic [CNT_W-1:0] load_in,
    output logic                  busy_out,
    output logic                  done_out
);
    typedef enum logic {DSCC_TMR_IDLE, DSCC_TMR_WAIT} dscc_tmr_state_t;

    dscc_tmr_state_t  state_q;
    dscc_tmr_state_t  state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    assign busy_out = (state_q == DSCC_TMR_WAIT);
    assign done_out = busy_out && (cnt_q == '0);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            DSCC_TMR_IDLE: begin
                if (start_in) begin
                    state_d = DSCC_TMR_WAIT;
                    cnt_d   = load_in;
                end
            end
            DSCC_TMR_WAIT: begin
                if (cnt_q == '0)
                    state_d = DSCC_TMR_IDLE;
                else
                    cnt_d = cnt_q - CNT_W'(1);
            end
            default: state_d = DSCC_TMR_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= DSCC_TMR_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end
endmodule // dscc_reply_timer
`default_nettype wire

// *** bench/dscc_host.sv ***
// Host model issuing settings commands and collecting delayed replies
`timescale 1ns/1ns
`default_nettype none
module dscc_host (
    input  wire logic        sys_clk_in,
    input  wire logic        ready_in,
    input  wire logic        rvalid_in,
    input  wire logic [15:0] rdata_in,
    input  wire logic        rnak_in,
    output logic             valid_out,
    output logic             write_out,
    output logic [2:0]       sel_out,
    output logic [15:0]      data_out
);
    initial begin
        valid_out = 1'b0;
        write_out = 1'b0;
        sel_out   = 3'h0;
        data_out  = 16'h0000;
    end
    // One command; waits for its reply when one is due and counts the cycles
    task automatic xfer(input logic w, input logic [2:0] s, input logic [15:0] d, input bit rep,
                        output logic [15:0] rd, output logic nk, output int cy);
        @(negedge sys_clk_in);
        valid_out = 1'b1;
        write_out = w;
        sel_out   = s;
        data_out  = d;
        // Ready is decoded from registers, so its level here is what the next rising edge samples
        while (ready_in !== 1'b1) @(negedge sys_clk_in);
        @(negedge sys_clk_in);
        valid_out = 1'b0;
        cy = 1;
        rd = 16'h0000;
        nk = 1'b0;
        if (rep) begin
            while (rvalid_in !== 1'b1 && cy < 1000) begin
                @(negedge sys_clk_in);
                cy++;
            end
            rd = rdata_in;
            nk = rnak_in;
        end
        @(negedge sys_clk_in);
    endtask
endmodule // dscc_host
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the comm configuration block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        sys_clk_in = 1'b0;
    logic        rst_n_in, msg_busy, ready, rv, nak, dhcp, pdone, cv, cw, nk;
    logic [3:0]  mode;
    logic [2:0]  nv, sel, br, cb;
    logic [15:0] cd, rdat, rd;
    logic [8:0]  proto;
    logic [6:0]  td, co;
    logic [5:0]  da;
    logic [7:0]  dch;
    logic [16:0] bps;
    logic [19:0] cbps;
    logic [31:0] net;
    int          bad_count = 0, comparisons = 0, cy;
    localparam logic [16:0] BRB [6] = '{17'h0, 17'h02580, 17'h04B00, 17'h09600, 17'h0E100, 17'h1C200};
    localparam logic [19:0] CBB [8] = '{20'hF4240, 20'hC3500, 20'h7A120, 20'h3D090,
                                        20'h1E848, 20'h0C350, 20'h061A8, 20'h030D4};
    localparam logic [6:0]  COI [4] = '{7'h10, 7'h02, 7'h0E, 7'h0F};
    localparam logic [31:0] CON [4] = '{32'h0A0A0A0A, 32'hC0A80114, 32'hC0A8008C, 32'h0};
    localparam logic [5:0]  DAI [4] = '{6'h09, 6'h0A, 6'h11, 6'h20};
    localparam logic [7:0]  DAC [4] = '{8'h39, 8'h3A, 8'h21, 8'h30};
    localparam logic [2:0]  BSL [10] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h0, 3'h6};
    localparam logic [15:0] BVL [10] = '{16'h0065, 16'h0, 16'h6, 16'h0, 16'h21, 16'h0, 16'h80,
                                         16'h8, 16'h0200, 16'h0};
    always #4 sys_clk_in = ~sys_clk_in;
    dscc_config #(.TD_UNIT_CYCLES(2), .POWERUP_CYCLES(20)) i_dscc_config (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cv), .cmd_write_in(cw),
        .cmd_sel_in(sel), .cmd_data_in(cd), .msg_busy_in(msg_busy),
        .power_up_operating_mode_in(mode), .nv_bit_rate_code_in(nv), .cmd_ready_out(ready),
        .reply_valid_out(rv), .reply_data_out(rdat), .reply_nak_out(nak),
        .protocol_settings_out(proto), .reply_transmit_delay_out(td),
        .serial_bit_rate_code_out(br), .serial_bit_rate_bps_out(bps),
        .multidrop_drive_address_out(da), .drive_address_char_out(dch),
        .node_id_or_net_index_out(co), .net_address_out(net), .net_dhcp_out(dhcp),
        .fieldbus_bit_rate_code_out(cb), .fieldbus_bit_rate_bps_out(cbps),
        .powerup_done_out(pdone));
    dscc_host u_host (.sys_clk_in(sys_clk_in), .ready_in(ready), .rvalid_in(rv), .rdata_in(rdat),
        .rnak_in(nak),
        .valid_out(cv), .write_out(cw), .sel_out(sel), .data_out(cd));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Command with reply; checks data and nak, then lets the view outputs settle
    task automatic cmd(input logic w, input logic [2:0] s, input logic [15:0] d,
                       input logic [15:0] ed, input logic en);
        u_host.xfer(w, s, d, 1'b1, rd, nk, cy);
        chk({31'h0, cy < 1000}, 32'h1);
        chk({16'h0, rd}, {16'h0, ed});
        chk({31'h0, nk}, {31'h0, en});
        repeat (2) @(negedge sys_clk_in);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
    initial begin
        rst_n_in = 1'b0;
        msg_busy = 1'b0;
        mode = 4'h1;
        nv = 3'h4;
        repeat (2) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        chk({23'h0, proto}, 32'h00F);
        chk({25'h0, td}, 32'h2);
        chk({15'h0, bps}, 32'h2580);
        chk({24'h0, dch}, 32'h30);
        chk({25'h0, co}, 32'h1);
        chk(net, 32'hC0A8010A);
        chk({12'h0, cbps}, 32'hF4240);
        chk({31'h0, ready}, 32'h1);
        for (int i = 0; i < 40 && pdone !== 1'b1; i++) @(negedge sys_clk_in);
        chk({31'h0, pdone}, 32'h1);
        chk({29'h0, br}, 32'h4);
        $display("test reset and power-up done");
        u_host.xfer(1'b0, 3'h0, 16'h0, 1'b1, rd, nk, cy);
        chk(cy, 5);
        chk({16'h0, rd}, 32'h00F);
        cmd(1'b1, 3'h1, 16'h0, 16'h0, 1'b0);
        u_host.xfer(1'b0, 3'h0, 16'h0, 1'b1, rd, nk, cy);
        chk(cy, 1);
        cmd(1'b1, 3'h0, 16'h01F5, 16'h0, 1'b0);
        chk({23'h0, proto}, 32'h1F5);
        cmd(1'b0, 3'h0, 16'h0, 16'h01F5, 1'b0);
        $display("test delay and protocol word done");
        for (int i = 1; i < 6; i++) begin
            cmd(1'b1, 3'h2, 16'(i), 16'h0, 1'b0);
            chk({15'h0, bps}, {15'h0, BRB[i]});
        end
        for (int i = 0; i < 8; i++) begin
            cmd(1'b1, 3'h5, 16'(i), 16'h0, 1'b0);
            chk({12'h0, cbps}, {12'h0, CBB[i]});
        end
        for (int i = 0; i < 4; i++) begin
            cmd(1'b1, 3'h3, {10'h0, DAI[i]}, 16'h0, 1'b0);
            chk({24'h0, dch}, {24'h0, DAC[i]});
            cmd(1'b1, 3'h4, {9'h0, COI[i]}, 16'h0, 1'b0);
            chk({25'h0, co}, {25'h0, COI[i]});
            chk(net, CON[i]);
            chk({31'h0, dhcp}, {31'h0, i == 3});
        end
        $display("test setting decodes done");
        for (int i = 0; i < 10; i++) cmd(1'b1, BSL[i], BVL[i], 16'h0, 1'b1);
        chk({19'h0, td, br, cb}, {19'h0, 7'h0, 3'h5, 3'h7});
        chk({10'h0, da, co, proto}, {10'h0, 6'h20, 7'h0F, 9'h1F5});
        $display("test refused writes done");
        cmd(1'b1, 3'h1, 16'h1, 16'h0, 1'b0);
        chk({25'h0, td}, 32'h1);
        msg_busy = 1'b1;
        u_host.xfer(1'b1, 3'h5, 16'h3, 1'b0, rd, nk, cy);
        repeat (4) @(negedge sys_clk_in);
        chk({29'h0, cb}, 32'h7);
        chk({31'h0, ready}, 32'h0);
        msg_busy = 1'b0;
        repeat (20) @(negedge sys_clk_in);
        chk({29'h0, cb}, 32'h3);
        $display("test busy message done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
